// ==== common/can_bt_pkg.sv ====
package can_bt_pkg;
   // ==================================================
   // register word indices (byte address = index * 4)
   localparam logic [5:0] IDX_PH2_WAKE = 6'h28;
   localparam logic [5:0] IDX_SEG_SAMP = 6'h29;
   localparam logic [5:0] IDX_PRE_JUMP = 6'h2a;
   localparam logic [5:0] IDX_MODE = 6'h30;
   localparam logic [5:0] IDX_STATUS = 6'h31;

   // ==================================================
   // field positions
   localparam int unsigned PRE_BRP_LSB = 0;
   localparam int unsigned PRE_SJW_LSB = 6;
   localparam int unsigned SEG_PROP_LSB = 0;
   localparam int unsigned SEG_PH1_LSB = 3;
   localparam int unsigned SEG_TRIPLE_BIT = 6;
   localparam int unsigned SEG_SRC_BIT = 7;
   localparam int unsigned P2_LEN_LSB = 0;
   localparam int unsigned P2_WAKE_BIT = 6;
   localparam int unsigned MODE_CFG_BIT = 0;
   // only the length field and the wake filter bit are stored
   localparam logic [7:0] P2_WRITE_MASK = 8'h47;

   // ==================================================
   // reset values
   localparam logic [7:0] PRE_JUMP_RST = 8'h00;
   localparam logic [7:0] SEG_SAMP_RST = 8'h00;
   localparam logic [7:0] PH2_WAKE_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h01;

   // ==================================================
   // timing, in time quanta
   localparam logic [3:0] SYNC_QUANTA = 4'h1;
   localparam logic [3:0] PROC_TIME_QUANTA = 4'h2;

   typedef enum logic [1:0] {
      SEG_SYNC = 2'b00,
      SEG_PROP = 2'b01,
      SEG_PH1 = 2'b10,
      SEG_PH2 = 2'b11
   } seg_t;
endpackage

// ==== rtl/tq_prescaler.sv ====
`timescale 1ns/1ps
// ==================================================
// quantum generator: half tick every prescaler+1 cycles, quantum every second half
module tq_prescaler (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_restart,
   input wire logic [5:0] i_brp,
   output logic o_half_tick,
   output logic o_tq_tick
);
   logic [5:0] cnt_r;
   logic phase_r;
   logic wrap;

   // >= rather than == so a lowered prescaler cannot strand the counter
   assign wrap = (cnt_r >= i_brp);
   assign o_half_tick = ~i_restart & wrap;
   assign o_tq_tick = o_half_tick & phase_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 6'h00;
         phase_r <= 1'b0;
      end else if (i_restart) begin
         cnt_r <= 6'h00;
         phase_r <= 1'b0;
      end else if (wrap) begin
         cnt_r <= 6'h00;
         phase_r <= ~phase_r;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end
endmodule

// ==== rtl/bt_majority.sv ====
`timescale 1ns/1ps
// ==================================================
// bit value resolver: single sample or two-of-three vote
module bt_majority (
   input wire logic i_triple,
   input wire logic i_now,
   input wire logic i_half,
   input wire logic i_full,
   output logic o_bit
);
   logic vote;

   assign vote = (i_now & i_half) | (i_now & i_full) | (i_half & i_full);
   assign o_bit = i_triple ? vote : i_now;
endmodule

// ==== rtl/can_bit_timing.sv ====
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module can_bit_timing (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_bus_receive_pin,
   input wire logic i_bus_idle,
   input wire logic i_tx_dominant,
   output logic o_rx_bit,
   output logic o_sample_pulse,
   output logic o_bit_start,
   output logic o_wake_filter_en
);
   // ==================================================
   // register file
   logic [7:0] pre_jump_r;
   logic [7:0] seg_samp_r;
   logic [7:0] ph2_wake_r;
   logic [7:0] mode_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic req;
   logic wr_en;
   logic cfg_mode;
   logic [7:0] status;

   function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
      return (adr[7:2] == idx) && (adr[1:0] == 2'b00);
   endfunction

   assign req = i_wb_cyc & i_wb_stb & ~ack_r;
   // a write lands on the edge that samples ack, where the master completes it
   assign wr_en = i_wb_cyc & i_wb_stb & ack_r & i_wb_we & i_wb_sel[0];
   assign cfg_mode = mode_r[can_bt_pkg::MODE_CFG_BIT];
   assign o_wb_ack = ack_r;
   assign o_wb_dat = rdat_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // timing registers only move in configuration mode
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_jump_r <= can_bt_pkg::PRE_JUMP_RST;
         seg_samp_r <= can_bt_pkg::SEG_SAMP_RST;
         ph2_wake_r <= can_bt_pkg::PH2_WAKE_RST;
      end else if (wr_en && cfg_mode) begin
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_PRE_JUMP)) begin
            pre_jump_r <= i_wb_dat[7:0];
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_SEG_SAMP)) begin
            seg_samp_r <= i_wb_dat[7:0];
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_PH2_WAKE)) begin
            ph2_wake_r <= i_wb_dat[7:0] & can_bt_pkg::P2_WRITE_MASK;
         end
      end
   end

   // mode register itself is always writable so software can leave and reenter
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r <= can_bt_pkg::MODE_RST;
      end else if (wr_en && reg_hit(i_wb_adr, can_bt_pkg::IDX_MODE)) begin
         mode_r <= {7'h00, i_wb_dat[can_bt_pkg::MODE_CFG_BIT]};
      end
   end

   // unmapped addresses answer with zero and ignore writes
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdat_r <= 32'h0000_0000;
      end else if (req) begin
         rdat_r <= 32'h0000_0000;
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_PRE_JUMP)) begin
            rdat_r[7:0] <= pre_jump_r;
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_SEG_SAMP)) begin
            rdat_r[7:0] <= seg_samp_r;
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_PH2_WAKE)) begin
            rdat_r[7:0] <= ph2_wake_r;
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_MODE)) begin
            rdat_r[7:0] <= mode_r;
         end
         if (reg_hit(i_wb_adr, can_bt_pkg::IDX_STATUS)) begin
            rdat_r[7:0] <= status;
         end
      end
   end

   // ==================================================
   // decoded timing
   logic [5:0] brp;
   logic [3:0] sjw;
   logic [3:0] prop_len;
   logic [3:0] ph1_len;
   logic [3:0] ph2_len;
   logic [3:0] ph1_eff;
   logic [3:0] ph2_eff;
   logic [3:0] seg_len;
   logic [3:0] ph1_ext_r;
   logic [3:0] ph2_cut_r;
   logic triple;
   logic ph2_src;

   assign brp = pre_jump_r[can_bt_pkg::PRE_BRP_LSB +: 6];
   assign sjw = {2'b00, pre_jump_r[can_bt_pkg::PRE_SJW_LSB +: 2]} + 4'h1;
   assign prop_len = {1'b0, seg_samp_r[can_bt_pkg::SEG_PROP_LSB +: 3]} + 4'h1;
   assign ph1_len = {1'b0, seg_samp_r[can_bt_pkg::SEG_PH1_LSB +: 3]} + 4'h1;
   assign triple = seg_samp_r[can_bt_pkg::SEG_TRIPLE_BIT];
   assign ph2_src = seg_samp_r[can_bt_pkg::SEG_SRC_BIT];

   always_comb begin
      if (ph2_src) begin
         ph2_len = {1'b0, ph2_wake_r[can_bt_pkg::P2_LEN_LSB +: 3]} + 4'h1;
      end else if (ph1_len > can_bt_pkg::PROC_TIME_QUANTA) begin
         ph2_len = ph1_len;
      end else begin
         ph2_len = can_bt_pkg::PROC_TIME_QUANTA;
      end
   end

   assign ph1_eff = ph1_len + ph1_ext_r;
   assign ph2_eff = ph2_len - ph2_cut_r;

   // ==================================================
   // quantum generation and pin history
   logic restart;
   logic half_tick;
   logic tq_tick;
   logic rx_prev_r;
   logic [1:0] hist_r;
   logic vote_bit;
   logic edge_fall;

   tq_prescaler u_presc (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_restart(restart),
      .i_brp(brp),
      .o_half_tick(half_tick),
      .o_tq_tick(tq_tick)
   );

   bt_majority u_vote (
      .i_triple(triple),
      .i_now(i_bus_receive_pin),
      .i_half(hist_r[0]),
      .i_full(hist_r[1]),
      .o_bit(vote_bit)
   );

   assign edge_fall = rx_prev_r & ~i_bus_receive_pin;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_prev_r <= 1'b1;
      end else begin
         rx_prev_r <= i_bus_receive_pin;
      end
   end

   // one entry per half quantum: [0] half a quantum back, [1] a full quantum back
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hist_r <= 2'b11;
      end else if (half_tick) begin
         hist_r <= {hist_r[0], i_bus_receive_pin};
      end
   end

   // ==================================================
   // segment sequencer and synchronisation
   can_bt_pkg::seg_t state_r;
   logic [3:0] qcnt_r;
   logic [4:0] qbit_r;
   logic synced_r;
   logic seg_last;
   logic hard_sync;
   logic resync;
   logic pos_err;
   logic small_err;
   logic [3:0] neg_mag;

   always_comb begin
      unique case (state_r)
         can_bt_pkg::SEG_SYNC: seg_len = can_bt_pkg::SYNC_QUANTA;
         can_bt_pkg::SEG_PROP: seg_len = prop_len;
         can_bt_pkg::SEG_PH1: seg_len = ph1_eff;
         can_bt_pkg::SEG_PH2: seg_len = ph2_eff;
      endcase
   end

   assign seg_last = (qcnt_r == (seg_len - 4'h1));
   assign pos_err = (state_r == can_bt_pkg::SEG_PROP) || (state_r == can_bt_pkg::SEG_PH1);
   assign neg_mag = ph2_eff - qcnt_r;
   assign small_err = pos_err ? (qbit_r <= {1'b0, sjw}) : (neg_mag <= sjw);
   assign hard_sync = i_bus_idle & edge_fall;
   // resync needs a recessive last sample, one per bit, none inside the sync segment
   assign resync = ~i_bus_idle & edge_fall & ~synced_r & o_rx_bit
                   & (state_r != can_bt_pkg::SEG_SYNC) & ~(pos_err & i_tx_dominant);
   // configuration mode parks the sequencer at the start of a bit
   assign restart = cfg_mode | hard_sync | (resync & small_err);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= can_bt_pkg::SEG_SYNC;
         qcnt_r <= 4'h0;
         qbit_r <= 5'h00;
      end else if (restart) begin
         state_r <= can_bt_pkg::SEG_SYNC;
         qcnt_r <= 4'h0;
         qbit_r <= 5'h00;
      end else if (tq_tick) begin
         qbit_r <= qbit_r + 5'h01;
         if (!seg_last) begin
            qcnt_r <= qcnt_r + 4'h1;
         end else begin
            qcnt_r <= 4'h0;
            unique case (state_r)
               can_bt_pkg::SEG_SYNC: state_r <= can_bt_pkg::SEG_PROP;
               can_bt_pkg::SEG_PROP: state_r <= can_bt_pkg::SEG_PH1;
               can_bt_pkg::SEG_PH1: state_r <= can_bt_pkg::SEG_PH2;
               can_bt_pkg::SEG_PH2: begin
                  state_r <= can_bt_pkg::SEG_SYNC;
                  qbit_r <= 5'h00;
               end
            endcase
         end
      end
   end

   // phase adjustments last for one bit only
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ph1_ext_r <= 4'h0;
         ph2_cut_r <= 4'h0;
         synced_r <= 1'b0;
      end else if (restart) begin
         ph1_ext_r <= 4'h0;
         ph2_cut_r <= 4'h0;
         synced_r <= hard_sync | resync;
      end else if (resync) begin
         synced_r <= 1'b1;
         if (pos_err) begin
            ph1_ext_r <= sjw;
         end else begin
            ph2_cut_r <= sjw;
         end
      end else if (tq_tick && seg_last && state_r == can_bt_pkg::SEG_PH2) begin
         ph1_ext_r <= 4'h0;
         ph2_cut_r <= 4'h0;
         synced_r <= 1'b0;
      end
   end

   // ==================================================
   // sampling and block outputs
   logic take_sample;
   logic bit_wrap;

   assign take_sample = tq_tick & seg_last & (state_r == can_bt_pkg::SEG_PH1) & ~restart;
   assign bit_wrap = tq_tick & seg_last & (state_r == can_bt_pkg::SEG_PH2) & ~restart;
   assign status = {5'h00, state_r, o_rx_bit};

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx_bit <= 1'b1;
         o_sample_pulse <= 1'b0;
      end else begin
         o_sample_pulse <= take_sample;
         if (take_sample) begin
            o_rx_bit <= vote_bit;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bit_start <= 1'b0;
         o_wake_filter_en <= 1'b0;
      end else begin
         o_bit_start <= bit_wrap | ((hard_sync | resync) & restart);
         o_wake_filter_en <= ph2_wake_r[can_bt_pkg::P2_WAKE_BIT];
      end
   end

   // ==================================================
   // assertions
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_cfg_write_lock: assert property (wr_en && !cfg_mode |=> $stable(seg_samp_r)
      && $stable(pre_jump_r) && $stable(ph2_wake_r)) else $error("timing reg changed");
   a_tq_min_period: assert property ((tq_tick && brp == 6'h00 && !restart) ##1 !restart
      ##1 !restart |-> tq_tick && !$past(tq_tick)) else $error("quantum not two cycles");
   a_prop_to_ph1: assert property (state_r == can_bt_pkg::SEG_PROP && tq_tick
      && qcnt_r == prop_len - 4'h1 && !restart |=> state_r == can_bt_pkg::SEG_PH1)
      else $error("propagation length wrong");
   a_sample_at_ph1: assert property (o_sample_pulse |-> $past(state_r)
      == can_bt_pkg::SEG_PH1 && $past(tq_tick)) else $error("sample off the point");
   a_single_sample: assert property (o_sample_pulse && !$past(triple)
      |-> o_rx_bit == $past(i_bus_receive_pin)) else $error("single sample wrong");
   a_triple_vote: assert property (take_sample && triple
      && hist_r[0] == hist_r[1] |=> o_rx_bit == $past(hist_r[0])) else $error("vote lost");
   a_ph2_fixed: assert property (!ph2_src && ph1_len < 4'h3
      |-> ph2_len == 4'h2) else $error("phase two below processing time");
   a_jump_bound: assert property (ph1_ext_r <= 4'h4 && ph2_cut_r <= sjw
      && (ph1_ext_r == 4'h0 || ph1_ext_r == sjw)) else $error("jump exceeds width");
   a_hard_sync: assert property (hard_sync |=> state_r == can_bt_pkg::SEG_SYNC
      && qcnt_r == 4'h0 && o_bit_start) else $error("hard sync did not restart");
   a_seg_order: assert property (state_r == can_bt_pkg::SEG_PH1 && !restart
      |=> state_r inside {can_bt_pkg::SEG_PH1, can_bt_pkg::SEG_PH2})
      else $error("segment order broken");
   a_wake_follow: assert property (##1 o_wake_filter_en
      == $past(ph2_wake_r[6])) else $error("wake filter output stale");

   c_triple_sample: cover property (take_sample && triple);
   c_resync_long: cover property (resync && pos_err && !small_err);
   c_resync_short: cover property (resync && !pos_err && !small_err);
   c_locked_write: cover property (wr_en && !cfg_mode);
endmodule

// ==== dv/can_node_model.sv ====
`timescale 1ns/1ps
// ==================================================
// other nodes on the shared bus
module can_node_model (
   input wire logic i_drive_dom,
   output logic o_bus_level
);
   // the line has a recessive pull, so a released bus reads 1, never the last value
   assign o_bus_level = ~i_drive_dom;
endmodule

// ==== dv/can_bit_timing_tb.sv ====
`timescale 1ns/1ps
module can_bit_timing_tb;
   // ==================================================
   // bench state
   typedef struct packed {
      logic [7:0] pre;
      logic [7:0] seg;
      logic [7:0] p2;
      logic [15:0] per;
      logic [15:0] off;
   } row_t;
   localparam logic [7:0] A_P2 = {can_bt_pkg::IDX_PH2_WAKE, 2'b00};
   localparam logic [7:0] A_SEG = {can_bt_pkg::IDX_SEG_SAMP, 2'b00};
   localparam logic [7:0] A_PRE = {can_bt_pkg::IDX_PRE_JUMP, 2'b00};
   localparam logic [7:0] A_MODE = {can_bt_pkg::IDX_MODE, 2'b00};
   localparam logic [7:0] A_STAT = {can_bt_pkg::IDX_STATUS, 2'b00};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic idle = 1'b0, dom = 1'b0, txd = 1'b0;
   logic [31:0] rdat, q_rd;
   logic ack, rxb, spl, bst, wake, pin;
   int num_errors = 0;
   int n_checks = 0;
   // bit time and sample offset in clock cycles; every row keeps the segment limits
   row_t rows [5] = '{
      '{8'h00, 8'h00, 8'h07, 16'h000a, 16'h0006},
      '{8'h01, 8'h3f, 8'h00, 16'h0064, 16'h0044},
      '{8'h00, 8'h9a, 8'h05, 16'h001c, 16'h0010},
      '{8'h02, 8'h8a, 8'h01, 16'h0030, 16'h0024},
      '{8'h3f, 8'h00, 8'h00, 16'h0280, 16'h0180}};

   initial begin
      forever #5 clk = ~clk;
   end

   can_bit_timing dut_u (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_bus_receive_pin(pin), .i_bus_idle(idle), .i_tx_dominant(txd), .o_rx_bit(rxb),
      .o_sample_pulse(spl), .o_bit_start(bst), .o_wake_filter_en(wake));
   can_node_model peer_u (.i_drive_dom(dom), .o_bus_level(pin));

   // ==================================================
   // helpers
   task automatic end_sim();
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic near(input int got, input int exp, input int tol);
      n_checks++;
      if (got < exp - tol || got > exp + tol) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // the slave answer latency is not assumed: wait for ack, the watchdog bounds it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q_rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      chk({31'h0, ack}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h0, d}, 4'h1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 32'h0, 4'h1);
      chk(q_rd, {24'h0, e});
   endtask

   task automatic cfg(input logic [7:0] pre, input logic [7:0] seg, input logic [7:0] p2);
      wr(A_MODE, 8'h01);
      wr(A_PRE, pre);
      wr(A_SEG, seg);
      wr(A_P2, p2);
      wr(A_MODE, 8'h00);
   endtask

   task automatic wait_p(input logic smp, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((smp ? spl : bst) !== 1'b1 && n < 3000);
      if (n >= 3000) chk(32'h1, 32'h0);
   endtask

   // hard sync aligns the bit, then a short pulse of the opposite level sits on the
   // sample point only, so the vote and the single sample give different bits
   task automatic trial(input logic triple_sample_sel, input logic inv);
      int n;
      idle <= 1'b1;
      dom <= 1'b1;
      wait_p(1'b0, n);
      idle <= 1'b0;
      dom <= inv;
      repeat (45) @(posedge clk);
      dom <= ~inv;
      repeat (4) @(posedge clk);
      dom <= inv;
      repeat (6) @(posedge clk);
      chk({31'h0, rxb}, {31'h0, triple_sample_sel ^ inv});
      dom <= 1'b0;
      repeat (200) @(posedge clk);
   endtask

   // edge dly+1 cycles into an 11-quantum bit of 8-cycle quanta (27: phase one,
   // 52: phase two); n counts cycles from driving the edge to the next bit start
   task automatic rs(input logic [1:0] sjw, input logic td, input int dly, input int exp);
      int n;
      cfg({sjw, 6'h03}, 8'h98, 8'h04);
      txd <= td;
      wait_p(1'b0, n);
      repeat (dly) @(posedge clk);
      dom <= 1'b1;
      wait_p(1'b0, n);
      near(n, exp, 2);
      dom <= 1'b0;
      txd <= 1'b0;
      repeat (200) @(posedge clk);
   endtask

   // ==================================================
   // main sequence
   initial begin
      int off, per, n;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         cfg(rows[i].pre, rows[i].seg, rows[i].p2);
         rd_chk(A_PRE, rows[i].pre);
         rd_chk(A_SEG, rows[i].seg);
         rd_chk(A_P2, rows[i].p2 & can_bt_pkg::P2_WRITE_MASK);
         wait_p(1'b0, n);
         wait_p(1'b1, off);
         wait_p(1'b0, per);
         near(off, rows[i].off, 2);
         near(off + per, rows[i].per, 0);
         chk({31'h0, rxb}, 32'h1);
      end
      wr(A_SEG, 8'h3f);
      rd_chk(A_SEG, 8'h00);
      wr(A_MODE, 8'h01);
      wr(A_P2, 8'hff);
      rd_chk(A_P2, 8'h47);
      chk({31'h0, wake}, 32'h1);
      wb(1'b1, A_P2, 32'h0, 4'h0);
      rd_chk(A_P2, 8'h47);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      chk({30'h0, rxb, wake}, 32'h2);
      rst_n <= 1'b1;
      rd_chk(A_P2, 8'h00);
      rd_chk(A_SEG, 8'h00);
      rd_chk(A_PRE, 8'h00);
      rd_chk(A_MODE, 8'h01);
      rd_chk(A_STAT, 8'h01);
      wr(8'hfc, 8'hff);
      rd_chk(8'hfc, 8'h00);
      rd_chk(8'ha5, 8'h00);
      for (int s = 0; s < 2; s++) begin
         for (int v = 0; v < 2; v++) begin
            cfg(8'h03, {1'b0, s[0], 6'h18}, 8'h00);
            trial(s[0], v[0]);
         end
      end
      rs(2'd0, 1'b0, 27, 69);
      rs(2'd3, 1'b0, 27, 2);
      rs(2'd3, 1'b1, 27, 61);
      rs(2'd0, 1'b1, 52, 28);
      rs(2'd3, 1'b0, 52, 4);
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
